// File: rtl/wdt_defs.svh
// Offsets, fields, reset values and timing counts of the watchdog block
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH
`define WDT_OFF_INIT 12'h000
`define WDT_OFF_COUNT 12'h004
`define WDT_OFF_CTRL 12'h008
`define WDT_OFF_STAT 12'h00C
`define WDT_OFF_MASK 12'h010
`define WDT_CTRL_HALT 0
`define WDT_CTRL_INHIBIT 1
`define WDT_CTRL_ALERT 2
`define WDT_CTRL_LOCK 3
`define WDT_EV_ZERO 0
`define WDT_EV_SECOND 1
`define WDT_EV_ALERT 2
`define WDT_CNT_W 10
`define WDT_INIT_RST 10'h004
`define WDT_MIN_CNT 10'h002
`define WDT_MAX_CNT 10'h3FF
`define WDT_PERIOD_MS 1200
`define WDT_CLK_KHZ 200000
`define WDT_PERIOD_CYC (`WDT_PERIOD_MS * `WDT_CLK_KHZ)
`define WDT_RST_PULSE_NS 1000
`define WDT_RST_PULSE_CYC (`WDT_RST_PULSE_NS / 5)
`endif

// File: rtl/wdt_pkg.sv
// Types shared by the watchdog block
package wdt_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } wdt_apb_req_t;
  typedef struct packed {
    logic halt;
    logic inhibit;
    logic alert_en;
    logic lock;
  } wdt_ctrl_t;
  typedef enum logic [1:0] {
    WDT_RUN,
    WDT_ARMED,
    WDT_RESET,
    WDT_DEAD
  } wdt_state_t;
endpackage

// File: rtl/wdt_tick.sv
// Count period prescaler: one pulse per count period
`timescale 1ns/1ps
`include "wdt_defs.svh"
module wdt_tick #(
  parameter int unsigned PERIOD_CYC = `WDT_PERIOD_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic restart,
  output logic tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } wdt_tick_st_t;
  wdt_tick_st_t s_q;
  wdt_tick_st_t s_d;
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (restart) begin
      s_d.cnt = 32'h0;
    end else if (s_q.cnt >= PERIOD_CYC - 1) begin
      s_d.cnt = 32'h0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick = s_q.tick;
endmodule // wdt_tick

// File: rtl/wdt_alert.sv
// Serialises a timeout alert code onto the LAN sideband
`timescale 1ns/1ps
module wdt_alert (
  input wire logic clk,
  input wire logic rst,
  input wire logic send,
  input wire logic [7:0] code,
  output logic busy,
  output logic txd,
  output logic txv
);
  typedef struct packed {
    logic [7:0] sh;
    logic [3:0] n;
    logic txd;
    logic txv;
  } wdt_alert_st_t;
  wdt_alert_st_t s_q;
  wdt_alert_st_t s_d;
  always_comb begin
    s_d = s_q;
    if (s_q.n != 4'h0) begin
      s_d.txd = s_q.sh[7];
      s_d.txv = 1'b1;
      s_d.sh = {s_q.sh[6:0], 1'b0};
      s_d.n = s_q.n - 4'h1;
    end else begin
      s_d.txd = 1'b0;
      s_d.txv = 1'b0;
      if (send) begin
        s_d.sh = code;
        s_d.n = 4'h8;
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign busy = (s_q.n != 4'h0);
  assign txd = s_q.txd;
  assign txv = s_q.txv;
endmodule // wdt_alert

// File: rtl/wdt_top.sv
// Watchdog down-counter with management interrupt, reset and alert
`timescale 1ns/1ps
`include "wdt_defs.svh"
module wdt_top #(
  parameter int unsigned PERIOD_CYC = `WDT_PERIOD_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [11:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic STRAP_REBOOT_INHIBIT,
  output logic MGMT_INTERRUPT,
  output logic IRQ,
  output logic PLATFORM_RESET,
  output logic ALERT_TXD,
  output logic ALERT_TXV
);
  typedef struct packed {
    logic [`WDT_CNT_W-1:0] init;
    logic [`WDT_CNT_W-1:0] count;
    wdt_pkg::wdt_ctrl_t ctrl;
    logic [2:0] stat;
    logic [2:0] mask;
    wdt_pkg::wdt_state_t state;
    logic strap;
    logic strap_seen;
    logic [7:0] rst_cnt;
    logic mgmt;
    logic irq;
    logic prst;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic alert_go;
  } wdt_st_t;
  wdt_st_t s_q;
  wdt_st_t s_d;
  wdt_pkg::wdt_apb_req_t req;
  logic tick;
  logic alert_busy;
  logic restart;
  logic wr;
  logic rd;
  logic [2:0] ev;
  logic blocked;

  // Register select decode, used for write and read paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  assign req = '{paddr: PADDR, psel: PSEL, penable: PENABLE,
                 pwrite: PWRITE, pwdata: PWDATA};
  assign wr = req.psel && req.penable && req.pwrite && !s_q.pready;
  assign rd = req.psel && req.penable && !req.pwrite && !s_q.pready;
  // Prescaler restarts on reload so the first period is a full one
  assign restart = wr && hit(req.paddr, `WDT_OFF_COUNT);
  assign blocked = s_q.strap || s_q.ctrl.lock;

  wdt_tick #(.PERIOD_CYC(PERIOD_CYC)) u_tick (
    .clk(REF_CLK),
    .rst(RST),
    .restart(restart),
    .tick(tick)
  );

  wdt_alert u_alert (
    .clk(REF_CLK),
    .rst(RST),
    .send(s_q.alert_go),
    .code({5'h0, s_q.stat}),
    .busy(alert_busy),
    .txd(ALERT_TXD),
    .txv(ALERT_TXV)
  );

  always_comb begin
    s_d = s_q;
    ev = 3'h0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.alert_go = 1'b0;
    // Strap is caught once, after reset release, never under reset
    if (!s_q.strap_seen) begin
      s_d.strap = STRAP_REBOOT_INHIBIT;
      s_d.strap_seen = 1'b1;
    end
    if (restart) begin
      s_d.count = s_q.init;
      if (s_q.state == wdt_pkg::WDT_ARMED) begin
        s_d.state = wdt_pkg::WDT_RUN;
      end
    end else if (tick && s_q.state != wdt_pkg::WDT_DEAD) begin
      if (!s_q.ctrl.halt) begin
        if (s_q.count > `WDT_CNT_W'(1)) begin
          s_d.count = s_q.count - `WDT_CNT_W'(1);
        end else if (s_q.state == wdt_pkg::WDT_RUN) begin
          s_d.count = s_q.init;
          s_d.state = wdt_pkg::WDT_ARMED;
          ev[`WDT_EV_ZERO] = 1'b1;
        end else if (s_q.state == wdt_pkg::WDT_ARMED) begin
          ev[`WDT_EV_SECOND] = 1'b1;
          s_d.count = s_q.init;
          if (!s_q.ctrl.inhibit && !blocked) begin
            s_d.state = wdt_pkg::WDT_RESET;
            s_d.rst_cnt = 8'(`WDT_RST_PULSE_CYC);
          end else begin
            s_d.state = wdt_pkg::WDT_RUN;
          end
          if (s_q.ctrl.alert_en && !alert_busy) begin
            s_d.alert_go = 1'b1;
            ev[`WDT_EV_ALERT] = 1'b1;
          end
        end
      end
    end
    if (s_q.state == wdt_pkg::WDT_RESET) begin
      if (s_q.rst_cnt == 8'h00) begin
        s_d.state = wdt_pkg::WDT_RUN;
      end else begin
        s_d.rst_cnt = s_q.rst_cnt - 8'h01;
      end
    end
    if (blocked) begin
      s_d.state = wdt_pkg::WDT_DEAD;
    end
    // APB writes; one wait cycle, then a PREADY cycle, per transfer
    if (wr) begin
      s_d.pready = 1'b1;
      if (hit(req.paddr, `WDT_OFF_INIT)) begin
        s_d.init = (req.pwdata[`WDT_CNT_W-1:0] == '0) ?
                   `WDT_MAX_CNT : req.pwdata[`WDT_CNT_W-1:0];
      end else if (hit(req.paddr, `WDT_OFF_CTRL)) begin
        s_d.ctrl.halt = req.pwdata[`WDT_CTRL_HALT];
        // Inhibit and lock are sticky once set, against errant software
        s_d.ctrl.inhibit = s_q.ctrl.inhibit | req.pwdata[`WDT_CTRL_INHIBIT];
        s_d.ctrl.alert_en = req.pwdata[`WDT_CTRL_ALERT];
        s_d.ctrl.lock = s_q.ctrl.lock | req.pwdata[`WDT_CTRL_LOCK];
      end else if (hit(req.paddr, `WDT_OFF_STAT)) begin
        s_d.stat = s_q.stat & ~req.pwdata[2:0];
      end else if (hit(req.paddr, `WDT_OFF_MASK)) begin
        s_d.mask = req.pwdata[2:0];
      end else if (!restart) begin
        s_d.pslverr = 1'b1;
      end
    end
    if (rd) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0;
      if (hit(req.paddr, `WDT_OFF_INIT)) begin
        s_d.prdata = {22'h0, s_q.init};
      end else if (hit(req.paddr, `WDT_OFF_COUNT)) begin
        s_d.prdata = {22'h0, s_q.count};
      end else if (hit(req.paddr, `WDT_OFF_CTRL)) begin
        s_d.prdata = {28'h0, s_q.ctrl.lock, s_q.ctrl.alert_en,
                      s_q.ctrl.inhibit, s_q.ctrl.halt};
        s_d.prdata[4] = (s_q.state == wdt_pkg::WDT_DEAD);
        s_d.prdata[5] = s_q.strap;
      end else if (hit(req.paddr, `WDT_OFF_STAT)) begin
        s_d.prdata = {29'h0, s_q.stat};
      end else if (hit(req.paddr, `WDT_OFF_MASK)) begin
        s_d.prdata = {29'h0, s_q.mask};
      end else begin
        s_d.pslverr = 1'b1;
      end
    end
    // Set wins over a same-cycle clear
    s_d.stat = s_d.stat | ev;
    s_d.mgmt = s_d.stat[`WDT_EV_ZERO] & s_d.mask[`WDT_EV_ZERO];
    s_d.irq = |(s_d.stat & s_d.mask);
    s_d.prst = (s_d.state == wdt_pkg::WDT_RESET);
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s_q <= '{init: `WDT_INIT_RST, count: `WDT_INIT_RST,
               ctrl: '0, stat: 3'h0, mask: 3'h0,
               state: wdt_pkg::WDT_RUN, strap: 1'b0, strap_seen: 1'b0,
               rst_cnt: 8'h00, mgmt: 1'b0, irq: 1'b0, prst: 1'b0,
               prdata: 32'h0, pready: 1'b0, pslverr: 1'b0,
               alert_go: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign PRDATA = s_q.prdata;
  assign PREADY = s_q.pready;
  assign PSLVERR = s_q.pslverr;
  assign MGMT_INTERRUPT = s_q.mgmt;
  assign IRQ = s_q.irq;
  assign PLATFORM_RESET = s_q.prst;
endmodule // wdt_top

// File: sim/wdt_props.sv
// Port-level checks of the watchdog block
`timescale 1ns/1ps
`include "wdt_defs.svh"
module wdt_chk (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [11:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic STRAP_REBOOT_INHIBIT,
  input wire logic MGMT_INTERRUPT,
  input wire logic IRQ,
  input wire logic PLATFORM_RESET,
  input wire logic ALERT_TXV
);
  logic inh_q;
  logic lock_q;
  // Sticky copies, since the bits cannot be cleared by software
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      inh_q <= 1'b0;
      lock_q <= 1'b0;
    end else if (PSEL && PENABLE && PWRITE && PREADY &&
                 PADDR == `WDT_OFF_CTRL) begin
      inh_q <= inh_q | PWDATA[1];
      lock_q <= lock_q | PWDATA[3];
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence s_wait;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence s_frame;
    ALERT_TXV [*8] ##1 !ALERT_TXV;
  endsequence
  a_ready_one_wait: assert property (s_wait |=> PREADY)
    else $error("ready not one cycle after access");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_mgmt_in_irq: assert property (MGMT_INTERRUPT |-> IRQ)
    else $error("management interrupt without irq");
  a_strap_no_reset: assert property (STRAP_REBOOT_INHIBIT |-> !PLATFORM_RESET)
    else $error("reset despite strap");
  a_inhibit_no_reset: assert property (inh_q |-> !$rose(PLATFORM_RESET))
    else $error("reset despite inhibit");
  a_lock_no_reset: assert property (lock_q |-> !$rose(PLATFORM_RESET))
    else $error("reset after lock");
  a_alert_frame: assert property ($rose(ALERT_TXV) |-> s_frame)
    else $error("alert frame not eight bits");
  a_reset_held: assert property ($rose(PLATFORM_RESET) |-> PLATFORM_RESET [*8])
    else $error("platform reset too short");
endmodule // wdt_chk
bind wdt_top wdt_chk u_chk (.REF_CLK(REF_CLK), .RST(RST), .PADDR(PADDR),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .STRAP_REBOOT_INHIBIT(STRAP_REBOOT_INHIBIT),
  .MGMT_INTERRUPT(MGMT_INTERRUPT), .IRQ(IRQ),
  .PLATFORM_RESET(PLATFORM_RESET), .ALERT_TXV(ALERT_TXV));

// File: sim/tb_watchdog_timeout_reset.sv
// Self-checking bench of the watchdog block
`timescale 1ns/1ps
`include "wdt_defs.svh"
module tb_watchdog_timeout_reset;
  localparam int P = 10;
  logic REF_CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
  logic PWRITE = 1'b0, STRAP_REBOOT_INHIBIT = 1'b0, err;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, MGMT_INTERRUPT, IRQ, PLATFORM_RESET;
  logic ALERT_TXD, ALERT_TXV;
  int bad_count = 0, compares = 0, n, k, cyc = 0, t0, m_init;
  wire logic [2:0] ev = {ALERT_TXV, PLATFORM_RESET, MGMT_INTERRUPT};
  wdt_top #(.PERIOD_CYC(P)) uut (.REF_CLK(REF_CLK), .RST(RST),
    .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .STRAP_REBOOT_INHIBIT(STRAP_REBOOT_INHIBIT), .MGMT_INTERRUPT(MGMT_INTERRUPT),
    .IRQ(IRQ), .PLATFORM_RESET(PLATFORM_RESET), .ALERT_TXD(ALERT_TXD),
    .ALERT_TXV(ALERT_TXV));
  initial forever #2.5 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) cyc <= cyc + 1;
  task automatic tally_and_finish;
    $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    PSEL <= 1'b1;
    PADDR <= a;
    PWRITE <= w;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    chk(n < 50, 1);
    if (n >= 50) tally_and_finish();
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask
  task automatic wait_hi(input int b, input int lim);
    n = 0;
    while (ev[b] !== 1'b1 && n < lim) begin
      @(posedge REF_CLK);
      n++;
    end
    chk(ev[b], 1);
    if (n >= lim) tally_and_finish();
  endtask
  task automatic quiet(input int lim);
    for (k = 0; k < lim; k++) begin
      @(posedge REF_CLK);
      chk(32'({PLATFORM_RESET, MGMT_INTERRUPT}), 0);
    end
  endtask
  task automatic do_reset(input logic s);
    RST <= 1'b1;
    STRAP_REBOOT_INHIBIT <= s;
    repeat (12) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    t0 = cyc;
  endtask
  initial begin
    void'($urandom(88524));
    do_reset(1'b0);
    apb(1'b0, `WDT_OFF_INIT, 0);
    chk(rd, 32'(`WDT_INIT_RST));
    apb(1'b0, `WDT_OFF_MASK, 0);
    chk(rd, 0);
    apb(1'b0, 12'h020, 0);
    chk(err, 1);
    $display("Test registers done");
    do_reset(1'b0);
    apb(1'b1, `WDT_OFF_MASK, 1);
    wait_hi(0, 12 * P);
    chk(cyc - t0 >= 4 * P && cyc - t0 <= 4 * P + 5, 1);
    apb(1'b1, `WDT_OFF_STAT, 1);
    apb(1'b0, `WDT_OFF_STAT, 0);
    chk(rd & 32'h7, 0);
    chk(IRQ, 0);
    wait_hi(1, 8 * P);
    chk(cyc - t0 >= 8 * P && cyc - t0 <= 8 * P + 8, 1);
    $display("Test unserviced timeout done");
    do_reset(1'b0);
    apb(1'b1, `WDT_OFF_MASK, 1);
    apb(1'b1, `WDT_OFF_COUNT, 0);
    apb(1'b1, `WDT_OFF_CTRL, 1);
    quiet(12 * P);
    $display("Test halt done");
    do_reset(1'b0);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `WDT_OFF_COUNT, 0);
      quiet(2 * P);
    end
    apb(1'b1, `WDT_OFF_MASK, 1);
    wait_hi(0, 6 * P);
    apb(1'b1, `WDT_OFF_INIT, 32'(`WDT_MIN_CNT));
    apb(1'b1, `WDT_OFF_COUNT, 0);
    apb(1'b0, `WDT_OFF_COUNT, 0);
    chk(rd, 32'(`WDT_MIN_CNT));
    wait_hi(1, 3 * `WDT_MIN_CNT * P);
    $display("Test service and handler done");
    do_reset(1'b0);
    m_init = `WDT_MIN_CNT + $urandom % 6;
    apb(1'b1, `WDT_OFF_INIT, 32'(m_init));
    apb(1'b1, `WDT_OFF_CTRL, 6);
    t0 = cyc;
    apb(1'b1, `WDT_OFF_COUNT, 0);
    apb(1'b0, `WDT_OFF_COUNT, 0);
    chk(rd, 32'(m_init));
    wait_hi(2, 2 * m_init * P + 4 * P);
    chk(cyc - t0 >= 2 * m_init * P && cyc - t0 <= 2 * m_init * P + 12, 1);
    // Alert code carries all three status events, first bit out first
    rd = 0;
    for (k = 0; k < 8; k++) begin
      rd[7 - k] = ALERT_TXD;
      @(posedge REF_CLK);
    end
    chk(rd, 32'h07);
    quiet(2 * P);
    apb(1'b0, `WDT_OFF_STAT, 0);
    chk(rd & 32'h7, 7);
    chk(IRQ, 0);
    $display("Test inhibit and alert done");
    do_reset(1'b1);
    apb(1'b0, `WDT_OFF_CTRL, 0);
    chk(rd[5], 1);
    quiet(10 * P);
    $display("Test strap done");
    do_reset(1'b0);
    apb(1'b1, `WDT_OFF_CTRL, 8);
    apb(1'b1, `WDT_OFF_CTRL, 0);
    apb(1'b0, `WDT_OFF_CTRL, 0);
    chk(rd & 32'h18, 32'h18);
    quiet(10 * P);
    $display("Test lock done");
    tally_and_finish();
  end
endmodule // tb_watchdog_timeout_reset
